// ### rtl/dcm_memory_ctrl.v
// Duplex/simplex redundant core memory controller with voted control
//
// Functional notes
// - In duplex mode the two modules form a pair and every data-port write lands identically in both.
// - In duplex mode a bad readout from one module is served from the mate and rewritten.
// - In simplex mode the top address bit picks the module, doubling usable capacity.
// - In simplex mode a bad readout is only reported, never repaired.
// - The processor commands the mode and the controller switches when next idle.
// - Instruction fetches and data accesses have separate address registers.
// - The store holds 32768 words of 28 bits including parity.
// - A data word is 26 payload bits plus 2 parity bits.
// - An instruction is 13 payload bits plus 1 parity bit, two per memory word.
// - Control state is held three times and a majority vote masks one bad copy.
// - Words move serially at 1.95 us bit times built from 0.49 us clock times; cycle 82.03 us.
`timescale 1ns/10ps
`default_nettype none
`include "dcm_consts.vh"
module dcm_memory_ctrl #(
  parameter MOD_AW   = `DCM_MOD_AW,
  parameter CLK_CYC  = (`DCM_CLKTIME_NS + `DCM_SYS_CLK_NS / 2) / `DCM_SYS_CLK_NS,
  parameter BIT_CLKS = (`DCM_BITTIME_NS + `DCM_CLKTIME_NS / 2) / `DCM_CLKTIME_NS,
  parameter CYC_CLKS = `DCM_CYCLE_NS / `DCM_SYS_CLK_NS
) (
  // Clock and reset
  input  wire                     clk,
  input  wire                     rst,
  // Mode command
  input  wire                     mode_cmd_valid,
  input  wire                     mode_cmd_duplex,
  // Instruction fetch port
  input  wire                     ifetch_req,
  input  wire [`DCM_IADDR_W-1:0]  ifetch_addr,
  output wire                     ifetch_done,
  output wire [`DCM_INSTR_W-1:0]  instr_word,
  // Data access port
  input  wire                     dacc_req,
  input  wire                     dacc_we,
  input  wire [`DCM_ADDR_W-1:0]   dacc_addr,
  input  wire [`DCM_DATA_W-1:0]   dacc_wdata,
  output wire                     dacc_done,
  output wire [`DCM_DATA_W-1:0]   dacc_rdata,
  // Fault injection write, raw word into one module
  input  wire                     fault_we,
  input  wire                     fault_mod,
  input  wire [MOD_AW-1:0]        fault_addr,
  input  wire [`DCM_WORD_W-1:0]   fault_word,
  // Status
  output wire                     busy,
  output wire                     mode_duplex,
  output wire                     err_fixed,
  output wire                     err_uncorr,
  output wire                     cycle_tick
);

  localparam W = `DCM_WORD_W;
  // One-hot control states
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_RD   = 5'h02;
  localparam [4:0] S_CHK  = 5'h04;
  localparam [4:0] S_REP  = 5'h08;
  localparam [4:0] S_SHF  = 5'h10;
  localparam [4:0] LAST_BIT = 5'h1B;

  // Majority of three copies
  function [9:0] vote3;
    input [9:0] a;
    input [9:0] b;
    input [9:0] c;
    begin
      vote3 = (a & b) | (a & c) | (b & c);
    end
  endfunction

  // Odd parity word build from 26 payload bits
  function [W-1:0] make_word;
    input [`DCM_DATA_W-1:0] d;
    begin
      make_word = {~(^d[25:13]), ~(^d[12:0]), d};
    end
  endfunction

  // Parity failure of the part of the word in use
  function word_bad;
    input [W-1:0] w;
    input         instr;
    input         syl;
    reg           lo_bad;
    reg           hi_bad;
    begin
      lo_bad = ~(^{w[26], w[12:0]});
      hi_bad = ~(^{w[27], w[25:13]});
      word_bad = instr ? (syl ? hi_bad : lo_bad) : (lo_bad | hi_bad);
    end
  endfunction

  // Triplicated control: {state, bit count}
  reg  [9:0]  ctl_a_reg;
  reg  [9:0]  ctl_b_reg;
  reg  [9:0]  ctl_c_reg;
  reg  [9:0]  ctl_next;
  wire [9:0]  ctl_v = vote3(ctl_a_reg, ctl_b_reg, ctl_c_reg);
  wire [4:0]  st    = ctl_v[9:5];
  wire [4:0]  bc    = ctl_v[4:0];

  // Timing dividers
  reg  [15:0] ct_cnt_reg;
  reg  [7:0]  bt_cnt_reg;
  reg  [15:0] cyc_cnt_reg;
  reg         bit_tick_reg;
  reg         cycle_tick_reg;

  // Operation registers
  reg                     op_instr_reg;
  reg                     op_we_reg;
  reg                     ipend_reg;
  reg [`DCM_IADDR_W-1:0]  iaddr_reg;
  reg [`DCM_ADDR_W-1:0]   daddr_reg;
  reg [W-1:0]             wword_reg;
  reg [W-1:0]             shift_reg;
  reg [W-1:0]             acc_reg;
  reg                     rep_mod_reg;
  reg [W-1:0]             rep_word_reg;
  reg                     fix_pend_reg;
  reg                     unc_pend_reg;
  reg                     mode_reg;
  reg                     mode_pend_reg;
  reg                     mode_pend_val_reg;
  // Output flops
  reg                     ifetch_done_reg;
  reg                     dacc_done_reg;
  reg [`DCM_INSTR_W-1:0]  instr_word_reg;
  reg [`DCM_DATA_W-1:0]   dacc_rdata_reg;
  reg                     err_fixed_reg;
  reg                     err_uncorr_reg;
  reg                     busy_reg;

  // Request acceptance
  wire take_d   = st[0] & dacc_req;
  wire take_i   = st[0] & ~dacc_req & (ifetch_req | ipend_reg);
  wire take_f   = st[0] & ~dacc_req & ~ifetch_req & ~ipend_reg & fault_we;

  // Current address split
  wire [`DCM_ADDR_W-1:0] cur_addr = op_instr_reg ? iaddr_reg[15:1] : daddr_reg;
  wire [MOD_AW-1:0]      mod_idx  = cur_addr[MOD_AW-1:0];
  wire                   mod_sel  = cur_addr[MOD_AW];
  wire                   syl      = iaddr_reg[0];

  // Module readouts and parity checks
  wire [W-1:0] rd_a;
  wire [W-1:0] rd_b;
  wire bad_a = word_bad(rd_a, op_instr_reg, syl);
  wire bad_b = word_bad(rd_b, op_instr_reg, syl);

  // Memory port steering
  wire wr_cycle = st[1] & op_we_reg;
  wire we_a = (wr_cycle & (mode_reg | ~mod_sel)) | (st[3] & ~rep_mod_reg) | (take_f & ~fault_mod);
  wire we_b = (wr_cycle & (mode_reg | mod_sel)) | (st[3] & rep_mod_reg) | (take_f & fault_mod);
  wire [MOD_AW-1:0] waddr = take_f ? fault_addr : mod_idx;
  wire [W-1:0]      wdata = st[3] ? rep_word_reg : (take_f ? fault_word : wword_reg);
  wire              re    = st[1] & ~op_we_reg;

  // Two modules of 16384 words make the 32768-word store
  dcm_core_mem #(.W(W), .AW(MOD_AW)) u_mod_a (
    .clk   (clk),
    .rst   (rst),
    .we    (we_a),
    .waddr (waddr),
    .wdata (wdata),
    .re    (re),
    .raddr (mod_idx),
    .rdata (rd_a)
  );

  dcm_core_mem #(.W(W), .AW(MOD_AW)) u_mod_b (
    .clk   (clk),
    .rst   (rst),
    .we    (we_b),
    .waddr (waddr),
    .wdata (wdata),
    .re    (re),
    .raddr (mod_idx),
    .rdata (rd_b)
  );

  // Readout selection and repair decision
  reg [W-1:0] sel_word;
  reg         need_rep;
  reg         rep_mod;
  reg         fixed;
  reg         uncorr;
  always @* begin
    sel_word = rd_a;
    need_rep = 1'b0;
    rep_mod  = 1'b0;
    fixed    = 1'b0;
    uncorr   = 1'b0;
    if (mode_reg) begin
      if (bad_a & bad_b) begin
        uncorr = 1'b1;
      end else if (bad_a) begin
        sel_word = rd_b;
        need_rep = 1'b1;
        fixed    = 1'b1;
      end else if (bad_b) begin
        need_rep = 1'b1;
        rep_mod  = 1'b1;
        fixed    = 1'b1;
      end
    end else begin
      sel_word = mod_sel ? rd_b : rd_a;
      uncorr   = mod_sel ? bad_b : bad_a;
    end
  end

  // Control next state
  always @* begin
    ctl_next = ctl_v;
    case (st)
      S_IDLE: begin
        if (take_d | take_i) begin
          ctl_next = {S_RD, 5'h00};
        end
      end
      S_RD: begin
        ctl_next = op_we_reg ? {S_SHF, 5'h00} : {S_CHK, 5'h00};
      end
      S_CHK: begin
        ctl_next = need_rep ? {S_REP, 5'h00} : {S_SHF, 5'h00};
      end
      S_REP: begin
        ctl_next = {S_SHF, 5'h00};
      end
      S_SHF: begin
        if (bit_tick_reg) begin
          ctl_next = (bc == LAST_BIT) ? {S_IDLE, 5'h00} : {S_SHF, bc + 5'h01};
        end
      end
      default: begin
        ctl_next = {S_IDLE, 5'h00};
      end
    endcase
  end

  // Three control copies, each reloaded from the vote
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_a_reg <= {S_IDLE, 5'h00};
      ctl_b_reg <= {S_IDLE, 5'h00};
      ctl_c_reg <= {S_IDLE, 5'h00};
    end else begin
      ctl_a_reg <= ctl_next;
      ctl_b_reg <= ctl_next;
      ctl_c_reg <= ctl_next;
    end
  end

  // Clock-time, bit-time and computer-cycle dividers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ct_cnt_reg     <= 16'h0000;
      bt_cnt_reg     <= 8'h00;
      cyc_cnt_reg    <= 16'h0000;
      bit_tick_reg   <= 1'b0;
      cycle_tick_reg <= 1'b0;
    end else begin
      bit_tick_reg   <= 1'b0;
      cycle_tick_reg <= 1'b0;
      if (ct_cnt_reg == CLK_CYC[15:0] - 16'h0001) begin
        ct_cnt_reg <= 16'h0000;
        if (bt_cnt_reg == BIT_CLKS[7:0] - 8'h01) begin
          bt_cnt_reg   <= 8'h00;
          bit_tick_reg <= 1'b1;
        end else begin
          bt_cnt_reg <= bt_cnt_reg + 8'h01;
        end
      end else begin
        ct_cnt_reg <= ct_cnt_reg + 16'h0001;
      end
      if (cyc_cnt_reg == CYC_CLKS[15:0] - 16'h0001) begin
        cyc_cnt_reg    <= 16'h0000;
        cycle_tick_reg <= 1'b1;
      end else begin
        cyc_cnt_reg <= cyc_cnt_reg + 16'h0001;
      end
    end
  end

  // Mode command held until the controller is idle
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_reg          <= `DCM_MODE_RST;
      mode_pend_reg     <= 1'b0;
      mode_pend_val_reg <= `DCM_MODE_RST;
    end else begin
      if (mode_cmd_valid) begin
        mode_pend_val_reg <= mode_cmd_duplex;
      end
      if (st[0] & (mode_pend_reg | mode_cmd_valid)) begin
        mode_reg      <= mode_cmd_valid ? mode_cmd_duplex : mode_pend_val_reg;
        mode_pend_reg <= 1'b0;
      end else if (mode_cmd_valid) begin
        mode_pend_reg <= 1'b1;
      end
    end
  end

  // Request capture, separate instruction and data address paths
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      op_instr_reg <= 1'b0;
      op_we_reg    <= 1'b0;
      ipend_reg    <= 1'b0;
      iaddr_reg    <= 16'h0000;
      daddr_reg    <= 15'h0000;
      wword_reg    <= 28'h0000000;
    end else begin
      if (ifetch_req & ~busy_reg & ~ipend_reg) begin
        iaddr_reg <= ifetch_addr;
        ipend_reg <= 1'b1;
      end
      if (take_d) begin
        op_instr_reg <= 1'b0;
        op_we_reg    <= dacc_we;
        daddr_reg    <= dacc_addr;
        wword_reg    <= make_word(dacc_wdata);
      end else if (take_i) begin
        op_instr_reg <= 1'b1;
        op_we_reg    <= 1'b0;
        ipend_reg    <= 1'b0;
        if (~ipend_reg) begin
          iaddr_reg <= ifetch_addr;
        end
      end
    end
  end

  // Readout handling, repair word and serial shift
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_reg    <= 28'h0000000;
      acc_reg      <= 28'h0000000;
      rep_mod_reg  <= 1'b0;
      rep_word_reg <= 28'h0000000;
      fix_pend_reg <= 1'b0;
      unc_pend_reg <= 1'b0;
    end else begin
      if (st[1]) begin
        shift_reg    <= wword_reg;
        fix_pend_reg <= 1'b0;
        unc_pend_reg <= 1'b0;
      end
      if (st[2]) begin
        shift_reg    <= sel_word;
        rep_word_reg <= sel_word;
        rep_mod_reg  <= rep_mod;
        fix_pend_reg <= fixed;
        unc_pend_reg <= uncorr;
      end
      if (st[4] & bit_tick_reg) begin
        shift_reg <= {1'b0, shift_reg[W-1:1]};
        acc_reg   <= {shift_reg[0], acc_reg[W-1:1]};
      end
    end
  end

  // Completion pulses and output data
  wire          fin      = st[4] & bit_tick_reg & (bc == LAST_BIT);
  wire [W-1:0]  fin_word = {shift_reg[0], acc_reg[W-1:1]};
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ifetch_done_reg <= 1'b0;
      dacc_done_reg   <= 1'b0;
      instr_word_reg  <= 13'h0000;
      dacc_rdata_reg  <= 26'h0000000;
      err_fixed_reg   <= 1'b0;
      err_uncorr_reg  <= 1'b0;
      busy_reg        <= 1'b0;
    end else begin
      ifetch_done_reg <= fin & op_instr_reg;
      dacc_done_reg   <= fin & ~op_instr_reg;
      err_fixed_reg   <= fin & fix_pend_reg;
      err_uncorr_reg  <= fin & unc_pend_reg;
      busy_reg        <= ~ctl_next[5];
      if (fin & op_instr_reg) begin
        instr_word_reg <= syl ? fin_word[25:13] : fin_word[12:0];
      end
      if (fin & ~op_instr_reg & ~op_we_reg) begin
        dacc_rdata_reg <= fin_word[25:0];
      end
    end
  end

  assign ifetch_done = ifetch_done_reg;
  assign dacc_done   = dacc_done_reg;
  assign instr_word  = instr_word_reg;
  assign dacc_rdata  = dacc_rdata_reg;
  assign err_fixed   = err_fixed_reg;
  assign err_uncorr  = err_uncorr_reg;
  assign busy        = busy_reg;
  assign mode_duplex = mode_reg;
  assign cycle_tick  = cycle_tick_reg;

endmodule // dcm_memory_ctrl
`default_nettype wire

// ### include/dcm_consts.vh
// Constants for the duplex core memory controller
`ifndef DCM_CONSTS_VH
`define DCM_CONSTS_VH

// Word layout
`define DCM_WORD_W      28
`define DCM_DATA_W      26
`define DCM_INSTR_W     13
`define DCM_ADDR_W      15
`define DCM_IADDR_W     16
`define DCM_MOD_AW      14
`define DCM_PAR_LO_BIT  27'd26
`define DCM_PAR_HI_BIT  27'd27
`define DCM_TOTAL_WORDS 32768

// Timing figures in nanoseconds
`define DCM_SYS_CLK_NS  40
`define DCM_CLKTIME_NS  490
`define DCM_BITTIME_NS  1950
`define DCM_CYCLE_NS    82030

// Reset values
`define DCM_MODE_RST    1'b1

`endif

// ### rtl/dcm_core_mem.v
// One ferrite-core memory module: registered read, single write port
`timescale 1ns/10ps
`default_nettype none
module dcm_core_mem #(
  parameter W  = 28,
  parameter AW = 14
) (
  // Clock and reset
  input  wire          clk,
  input  wire          rst,
  // Write port
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [W-1:0]  wdata,
  // Read port
  input  wire          re,
  input  wire [AW-1:0] raddr,
  output wire [W-1:0]  rdata
);

  reg [W-1:0] mem_reg [0:(1<<AW)-1];
  reg [W-1:0] rdata_reg;

  // Array write
  always @(posedge clk) begin
    if (we) begin
      mem_reg[waddr] <= wdata;
    end
  end

  // Registered readout
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= {W{1'b0}};
    end else if (re) begin
      rdata_reg <= mem_reg[raddr];
    end
  end

  assign rdata = rdata_reg;

endmodule // dcm_core_mem
`default_nettype wire

// ### sim/dcm_memory_ctrl_props.sv
// Port assertions for the memory controller
`timescale 1ns/10ps
`default_nettype none
module dcm_memory_ctrl_props #(
  parameter CLK_CYC  = 12,
  parameter BIT_CLKS = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Requests
  input wire logic mode_cmd_valid,
  input wire logic mode_cmd_duplex,
  input wire logic ifetch_req,
  input wire logic dacc_req,
  // Completions and status
  input wire logic ifetch_done,
  input wire logic dacc_done,
  input wire logic busy,
  input wire logic mode_duplex,
  input wire logic err_fixed,
  input wire logic err_uncorr,
  input wire logic cycle_tick
);
  localparam int BT      = CLK_CYC * BIT_CLKS;
  localparam int LAT_MIN = 27 * BT;
  localparam int LAT_MAX = 29 * BT + 6;
  // Single clock domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Taking and answering requests
  AST_TAKE_BUSY: assert property ((dacc_req || ifetch_req) && !busy |=> busy)
    else $error("request not taken");
  AST_DATA_LATENCY: assert property (dacc_req && !busy |-> ##[LAT_MIN:LAT_MAX] dacc_done)
    else $error("data access latency wrong");
  AST_FETCH_LATENCY: assert property
    (ifetch_req && !dacc_req && !busy |-> ##[LAT_MIN:LAT_MAX] ifetch_done)
    else $error("fetch latency wrong");
  AST_DONE_IDLE: assert property ((dacc_done || ifetch_done) |-> !busy && $past(busy))
    else $error("done without idle");
  AST_DONE_PULSE: assert property (dacc_done |=> !dacc_done)
    else $error("done longer than a cycle");
  AST_TICK_PULSE: assert property (cycle_tick |=> !cycle_tick)
    else $error("cycle tick longer than a cycle");
  // Error reporting
  AST_ERR_AT_DONE: assert property ((err_fixed || err_uncorr) |-> dacc_done || ifetch_done)
    else $error("error flag without done");
  AST_FIX_DUPLEX: assert property (err_fixed |-> mode_duplex && !err_uncorr)
    else $error("repair outside duplex");
  // Mode switching
  AST_MODE_APPLY: assert property
    (mode_cmd_valid && !busy && !dacc_req && !ifetch_req |=> mode_duplex == $past(mode_cmd_duplex))
    else $error("mode not applied");
  AST_MODE_HELD: assert property ($past(busy) |-> $stable(mode_duplex))
    else $error("mode changed while busy");
  // Main scenarios
  COV_FIX: cover property (err_fixed && dacc_done);
  COV_SIMPLEX_ERR: cover property (err_uncorr && !mode_duplex);
  COV_FETCH_FIX: cover property (err_fixed && ifetch_done);
endmodule // dcm_memory_ctrl_props
`default_nettype wire

// ### sim/dcm_cpu_model.sv
// Processor core model issuing fetches, data accesses and mode commands
`timescale 1ns/10ps
`default_nettype none
module dcm_cpu_model (
  // Clock
  input  wire logic        clk,
  // Requests toward the controller
  output var  logic        mode_cmd_valid,
  output var  logic        mode_cmd_duplex,
  output var  logic        ifetch_req,
  output var  logic [15:0] ifetch_addr,
  output var  logic        dacc_req,
  output var  logic        dacc_we,
  output var  logic [14:0] dacc_addr,
  output var  logic [25:0] dacc_wdata,
  output var  logic        fault_we,
  output var  logic        fault_mod,
  output var  logic [13:0] fault_addr,
  output var  logic [27:0] fault_word,
  // Answers from the controller
  input  wire logic        ifetch_done,
  input  wire logic [12:0] instr_word,
  input  wire logic        dacc_done,
  input  wire logic [25:0] dacc_rdata,
  input  wire logic        err_fixed,
  input  wire logic        err_uncorr
);
  // Idle levels at time zero
  initial {mode_cmd_valid, mode_cmd_duplex, ifetch_req, ifetch_addr, dacc_req, dacc_we,
           dacc_addr, dacc_wdata, fault_we, fault_mod, fault_addr, fault_word} = '0;
  // One data access, waits for its completion
  task automatic data_op(input logic we, input logic [14:0] a, input logic [25:0] wd,
                         output logic [25:0] rd, output logic [1:0] err);
    int n;
    @(posedge clk);
    dacc_req   <= 1'b1;
    dacc_we    <= we;
    dacc_addr  <= a;
    dacc_wdata <= wd;
    @(posedge clk);
    dacc_req   <= 1'b0;
    dacc_addr  <= ~a; // Released lines carry no stale value
    dacc_wdata <= ~wd;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (dacc_done !== 1'b1 && n < 100);
    // A missed completion returns unknowns so the caller's compare fails
    rd  = (dacc_done === 1'b1) ? dacc_rdata : 'x;
    err = (dacc_done === 1'b1) ? {err_uncorr, err_fixed} : 'x;
  endtask
  // One instruction fetch
  task automatic fetch_op(input logic [15:0] a, output logic [12:0] ins, output logic [1:0] err);
    int n;
    @(posedge clk);
    ifetch_req  <= 1'b1;
    ifetch_addr <= a;
    @(posedge clk);
    ifetch_req  <= 1'b0;
    ifetch_addr <= ~a;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (ifetch_done !== 1'b1 && n < 100);
    ins = (ifetch_done === 1'b1) ? instr_word : 'x;
    err = (ifetch_done === 1'b1) ? {err_uncorr, err_fixed} : 'x;
  endtask
  // Program-chosen memory mode
  task automatic set_mode(input logic dup);
    @(posedge clk);
    mode_cmd_valid  <= 1'b1;
    mode_cmd_duplex <= dup;
    @(posedge clk);
    mode_cmd_valid  <= 1'b0;
    @(negedge clk);
  endtask
  // Raw word into one module
  task automatic fault(input logic m, input logic [13:0] a, input logic [27:0] w);
    @(posedge clk);
    fault_we   <= 1'b1;
    fault_mod  <= m;
    fault_addr <= a;
    fault_word <= w;
    @(posedge clk);
    fault_we   <= 1'b0;
  endtask
endmodule // dcm_cpu_model
`default_nettype wire

// ### sim/dcm_memory_ctrl_tb.sv
// Self-checking bench for the memory controller
`timescale 1ns/10ps
`default_nettype none
module dcm_memory_ctrl_tb;
  logic        clk, rst, mode_cmd_valid, mode_cmd_duplex, ifetch_req, ifetch_done;
  logic        dacc_req, dacc_we, dacc_done, fault_we, fault_mod;
  logic        busy, mode_duplex, err_fixed, err_uncorr, cycle_tick;
  logic [15:0] ifetch_addr;
  logic [12:0] instr_word;
  logic [14:0] dacc_addr;
  logic [25:0] dacc_wdata, dacc_rdata;
  logic [13:0] fault_addr;
  logic [27:0] fault_word;
  int          failures;
  int          checks_done;
  localparam int CYC_TB = 64;
  // Controller with short dividers
  dcm_memory_ctrl #(.CLK_CYC(1), .BIT_CLKS(1), .CYC_CLKS(CYC_TB)) dcm_memory_ctrl_i (
    .clk(clk), .rst(rst), .mode_cmd_valid(mode_cmd_valid), .mode_cmd_duplex(mode_cmd_duplex),
    .ifetch_req(ifetch_req), .ifetch_addr(ifetch_addr), .ifetch_done(ifetch_done),
    .instr_word(instr_word), .dacc_req(dacc_req), .dacc_we(dacc_we), .dacc_addr(dacc_addr),
    .dacc_wdata(dacc_wdata), .dacc_done(dacc_done), .dacc_rdata(dacc_rdata),
    .fault_we(fault_we), .fault_mod(fault_mod), .fault_addr(fault_addr),
    .fault_word(fault_word), .busy(busy), .mode_duplex(mode_duplex), .err_fixed(err_fixed),
    .err_uncorr(err_uncorr), .cycle_tick(cycle_tick));
  // Processor side
  dcm_cpu_model dcm_cpu_model_i (
    .clk(clk), .mode_cmd_valid(mode_cmd_valid), .mode_cmd_duplex(mode_cmd_duplex),
    .ifetch_req(ifetch_req), .ifetch_addr(ifetch_addr), .dacc_req(dacc_req),
    .dacc_we(dacc_we), .dacc_addr(dacc_addr), .dacc_wdata(dacc_wdata), .fault_we(fault_we),
    .fault_mod(fault_mod), .fault_addr(fault_addr), .fault_word(fault_word),
    .ifetch_done(ifetch_done), .instr_word(instr_word), .dacc_done(dacc_done),
    .dacc_rdata(dacc_rdata), .err_fixed(err_fixed), .err_uncorr(err_uncorr));
  // Clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [27:0] got, input logic [27:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Stored word with odd parity per half
  function automatic logic [27:0] enc(input logic [25:0] d);
    return {~^d[25:13], ~^d[12:0], d};
  endfunction
  task automatic wr(input logic [14:0] a, input logic [25:0] d);
    logic [25:0] r;
    logic [1:0]  e;
    dcm_cpu_model_i.data_op(1'b1, a, d, r, e);
    chk({26'h0, e}, 28'h0);
  endtask
  task automatic rdc(input logic [14:0] a, input logic [25:0] d, input logic [1:0] e);
    logic [25:0] r;
    logic [1:0]  g;
    dcm_cpu_model_i.data_op(1'b0, a, 26'h0, r, g);
    chk({2'h0, r}, {2'h0, d});
    chk({26'h0, g}, {26'h0, e});
  endtask
  task automatic ftc(input logic [15:0] a, input logic [12:0] i, input logic [1:0] e);
    logic [12:0] r;
    logic [1:0]  g;
    dcm_cpu_model_i.fetch_op(a, r, g);
    chk({15'h0, r}, {15'h0, i});
    chk({26'h0, g}, {26'h0, e});
  endtask
  // Reset mode and mirrored, aliased words
  task automatic t_duplex;
    chk({27'h0, mode_duplex}, 28'h1);
    wr(15'h0005, 26'h2ABCDEF);
    rdc(15'h0005, 26'h2ABCDEF, 2'h0);
    rdc(15'h4005, 26'h2ABCDEF, 2'h0);
  endtask
  // One bad copy served from the mate, then rewritten
  task automatic t_repair;
    for (int m = 0; m < 2; m++) begin
      wr(15'h0010, 26'h1555555);
      dcm_cpu_model_i.fault(m[0], 14'h0010, enc(26'h1) ^ 28'h4000000);
      rdc(15'h0010, 26'h1555555, 2'h1);
      rdc(15'h0010, 26'h1555555, 2'h0);
    end
  endtask
  // Both copies bad: reported, never rewritten
  task automatic t_both_bad;
    wr(15'h0020, 26'h0ABC);
    dcm_cpu_model_i.fault(1'b0, 14'h0020, 28'h0);
    dcm_cpu_model_i.fault(1'b1, 14'h0020, 28'h3);
    rdc(15'h0020, 26'h0, 2'h2);
    rdc(15'h0020, 26'h0, 2'h2);
  endtask
  // Distinct modules, no repair
  task automatic t_simplex;
    dcm_cpu_model_i.set_mode(1'b0);
    chk({27'h0, mode_duplex}, 28'h0);
    wr(15'h0007, 26'h0111);
    wr(15'h4007, 26'h0222);
    rdc(15'h0007, 26'h0111, 2'h0);
    rdc(15'h4007, 26'h0222, 2'h0);
    dcm_cpu_model_i.fault(1'b0, 14'h0007, 28'h0);
    rdc(15'h0007, 26'h0, 2'h2);
    rdc(15'h0007, 26'h0, 2'h2);
    dcm_cpu_model_i.set_mode(1'b1);
    chk({27'h0, mode_duplex}, 28'h1);
  endtask
  // Two instructions per word, only the addressed half checked
  task automatic t_fetch;
    wr(15'h0033, 26'h2468ACE);
    ftc(16'h0066, 13'h0ACE, 2'h0);
    dcm_cpu_model_i.fault(1'b0, 14'h0033, enc(26'h2468ACE) ^ 28'h8000000);
    ftc(16'h0066, 13'h0ACE, 2'h0);
    ftc(16'h0067, 13'h1234, 2'h1);
  endtask
  // Mode command while busy waits for idle
  task automatic t_mode_hold;
    fork
      wr(15'h0040, 26'h0055);
      begin
        repeat (6) @(posedge clk);
        dcm_cpu_model_i.set_mode(1'b0);
      end
    join
    chk({27'h0, mode_duplex}, 28'h1);
    @(negedge clk);
    chk({27'h0, mode_duplex}, 28'h0);
    dcm_cpu_model_i.set_mode(1'b1);
    chk({27'h0, mode_duplex}, 28'h1);
  endtask
  // Computer-cycle marker period
  task automatic t_cycle;
    int n;
    n = 0;
    @(negedge clk);
    while (cycle_tick !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (cycle_tick !== 1'b1 && n < 200);
    chk(28'(n), 28'(CYC_TB));
  endtask
  task automatic stop_test;
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    failures    = 0;
    checks_done = 0;
    rst         = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_duplex();
    t_repair();
    t_both_bad();
    t_simplex();
    t_fetch();
    t_mode_hold();
    t_cycle();
    stop_test();
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    stop_test();
  end
endmodule // dcm_memory_ctrl_tb
bind dcm_memory_ctrl dcm_memory_ctrl_props #(.CLK_CYC(CLK_CYC), .BIT_CLKS(BIT_CLKS))
  dcm_memory_ctrl_props_i (.clk(clk), .rst(rst), .mode_cmd_valid(mode_cmd_valid),
  .mode_cmd_duplex(mode_cmd_duplex), .ifetch_req(ifetch_req), .dacc_req(dacc_req),
  .ifetch_done(ifetch_done), .dacc_done(dacc_done), .busy(busy), .mode_duplex(mode_duplex),
  .err_fixed(err_fixed), .err_uncorr(err_uncorr), .cycle_tick(cycle_tick));
`default_nettype wire
